// ---- design/pergen_top.sv ----
// profiling event record generator: counters, record build, word output
`timescale 1ns/1ns
module pergen_top
    import pergen_pkg::*;
#(
    parameter int CNT_W = 32,
    parameter int FRAC_W = 16
) (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic [7:0] core_id,
    input wire logic record_time_value_capture_flag,
    input wire logic [63:0] perf_record_time_value,
    input wire logic [63:0] instr_location,
    input wire logic [CNT_W-1:0] dmiss_interval,
    input wire logic [CNT_W-1:0] cnh_interval,
    input wire logic [CNT_W-1:0] rnh_interval,
    input wire logic counters_load,
    input wire logic [FRAC_W-1:0] ref_ratio,
    input wire logic stop_clock_input,
    input wire logic halt_instr,
    input wire logic dmiss_event,
    input wire logic [63:0] missed_data_location,
    input wire logic data_addr_valid,
    input wire logic [2:0] miss_source_code,
    input wire logic [31:0] miss_latency,
    input wire logic user_record_insert_instr,
    input wire logic [15:0] insert_imm,
    input wire logic [31:0] insert_operand_word,
    input wire logic [63:0] insert_operand_quad,
    input wire logic legacy_mode,
    input wire logic rec_ready,
    output logic rec_valid,
    output logic [4:0] rec_offset,
    output logic [63:0] rec_data,
    output logic rec_last,
    output logic busy
);
    // emitter state and the words of the record in flight
    perg_state_t state_reg;
    logic [63:0] words_reg [PERG_WORDS];
    logic [1:0] word_idx_reg;
    logic [63:0] next_word;
    logic word_taken;

    // counter records waiting for the emitter
    logic [2:0] pend_reg;
    logic dm_uf;
    logic cnh_uf;
    logic rnh_uf;

    // fields of the last miss
    logic [63:0] dm_addr_reg;
    logic dm_dav_reg;
    logic [2:0] dm_src_reg;
    logic [31:0] dm_lat_reg;
    logic [63:0] dm_ip_reg;

    // instruction address seen by the clock records
    logic [63:0] clk_ip_reg;

    // latched insert record
    logic [63:0] ins_w0_reg;
    logic [63:0] ins_w1_reg;
    logic [63:0] ins_w2_reg;
    logic ins_pend_reg;

    // halt tracking; stop pin through two flip-flops
    logic stop_s1_reg;
    logic stop_s2_reg;
    logic running;

    // counter steps in fixed point
    logic [CNT_W+FRAC_W-1:0] one_step;
    logic [CNT_W+FRAC_W-1:0] ref_step;

    // assembled record words
    logic [63:0] stamp_word;
    logic [63:0] dm_w0;
    logic [63:0] dm_w2;
    logic [63:0] q_ext;
    logic [63:0] cnh_w0;
    logic [63:0] rnh_w0;

    // arbitration between pending records
    logic start_emit;
    perg_kind_t pick_kind;
    logic pick_ins;
    logic pick_dm;
    logic pick_cnh;
    logic pick_rnh;
    logic [63:0] sel_w0;
    logic [63:0] sel_w1;
    logic [63:0] sel_w2;

    // header word with code and core id in bytes 0 and 1
    function automatic logic [63:0] header(input logic [7:0] code, input logic [7:0] cid);
        header = {48'h0000_0000_0000, cid, code};
    endfunction

    // stop clock pin is asynchronous; halt instruction is same-clock
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            stop_s1_reg <= 1'b0;
            stop_s2_reg <= 1'b0;
        end else begin
            stop_s1_reg <= stop_clock_input;
            stop_s2_reg <= stop_s1_reg;
        end
    end
    assign running = !stop_s2_reg && !halt_instr;
    // unit step for the miss and core clock counters
    assign one_step = {{(CNT_W-1){1'b0}}, 1'b1, {FRAC_W{1'b0}}};
    // constant-rate reference approximated by a fractional step per running cycle
    assign ref_step = {{CNT_W{1'b0}}, ref_ratio};


    // miss counter, one count per eligible load miss
    perg_counter #(.WIDTH(CNT_W), .FRAC(FRAC_W)) u_dmiss_cnt (
        .sys_clk(sys_clk),
        .reset_n(reset_n),
        .load(counters_load),
        .load_value(dmiss_interval),
        .dec(dmiss_event),
        .dec_amount(one_step),
        .underflow(dm_uf)
    );

    // core clock counter, one count per running cycle
    perg_counter #(.WIDTH(CNT_W), .FRAC(FRAC_W)) u_cnh_cnt (
        .sys_clk(sys_clk),
        .reset_n(reset_n),
        .load(counters_load),
        .load_value(cnh_interval),
        .dec(running),
        .dec_amount(one_step),
        .underflow(cnh_uf)
    );

    // reference counter, fractional step per running cycle
    perg_counter #(.WIDTH(CNT_W), .FRAC(FRAC_W)) u_rnh_cnt (
        .sys_clk(sys_clk),
        .reset_n(reset_n),
        .load(counters_load),
        .load_value(rnh_interval),
        .dec(running),
        .dec_amount(ref_step),
        .underflow(rnh_uf)
    );

    // instruction address of the previous cycle, for the clock records
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            clk_ip_reg <= 64'h0000_0000_0000_0000;
        end else begin
            clk_ip_reg <= instr_location;
        end
    end

    // capture every miss, so the miss record reports the last miss captured before the record starts
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            dm_addr_reg <= 64'h0000_0000_0000_0000;
            dm_dav_reg <= 1'b0;
            dm_src_reg <= 3'h0;
            dm_lat_reg <= 32'h0000_0000;
            dm_ip_reg <= 64'h0000_0000_0000_0000;
        end else if (dmiss_event) begin
            dm_addr_reg <= missed_data_location;
            dm_dav_reg <= data_addr_valid;
            dm_src_reg <= miss_source_code;
            dm_lat_reg <= miss_latency;
            dm_ip_reg <= instr_location;
        end
    end

    // record_time_value word, zero unless capture was asked for
    assign stamp_word = record_time_value_capture_flag ? perf_record_time_value
        : 64'h0000_0000_0000_0000;

    // miss record word 0: code, core id, valid flag, source, latency
    assign dm_w0 = header(PERG_CODE_DMISS, core_id)
        | ({63'h0, dm_dav_reg} << PERG_DAV_BIT)
        | ({61'h0, dm_src_reg} << PERG_SRC_LSB)
        | ({32'h0000_0000, dm_lat_reg} << PERG_HI_LSB);
    // data address word, zero when the address is unavailable
    assign dm_w2 = dm_dav_reg ? dm_addr_reg : 64'h0000_0000_0000_0000;
    // insert operand, upper half cleared in legacy mode
    assign q_ext = legacy_mode ? {32'h0000_0000, insert_operand_quad[31:0]}
        : insert_operand_quad;

    // generic clock records: code and core id only, the rest reserved
    assign cnh_w0 = header(PERG_CODE_CNH, core_id);
    assign rnh_w0 = header(PERG_CODE_RNH, core_id);

    // insert instruction latched so it waits out a busy emitter
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            ins_pend_reg <= 1'b0;
            ins_w0_reg <= 64'h0000_0000_0000_0000;
            ins_w1_reg <= 64'h0000_0000_0000_0000;
            ins_w2_reg <= 64'h0000_0000_0000_0000;
        end else if (user_record_insert_instr && !ins_pend_reg) begin
            ins_pend_reg <= 1'b1;
            ins_w0_reg <= header(PERG_CODE_INS, core_id)
                | ({48'h0, insert_imm} << PERG_IMM_LSB)
                | ({32'h0000_0000, insert_operand_word} << PERG_HI_LSB);
            ins_w1_reg <= instr_location;
            ins_w2_reg <= q_ext;
        end else if (pick_ins) begin
            ins_pend_reg <= 1'b0;
        end
    end

    // an idle emitter starts as soon as any record waits
    assign start_emit = (state_reg == PERG_ST_IDLE) && (ins_pend_reg || (pend_reg != 3'h0));

    // fixed priority: insert, then miss, core clocks, reference clocks
    assign pick_kind = ins_pend_reg ? PERG_K_INS
        : pend_reg[0] ? PERG_K_DMISS
        : pend_reg[1] ? PERG_K_CNH
        : PERG_K_RNH;
    assign pick_ins = start_emit && (pick_kind == PERG_K_INS);
    assign pick_dm = start_emit && (pick_kind == PERG_K_DMISS);
    assign pick_cnh = start_emit && (pick_kind == PERG_K_CNH);
    assign pick_rnh = start_emit && (pick_kind == PERG_K_RNH);

    // pending counter records: bit0 miss, bit1 core clocks, bit2 reference clocks
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            pend_reg <= 3'h0;
        end else begin
            // a new underflow wins over the clear of the same slot
            pend_reg <= (pend_reg & ~{pick_rnh, pick_cnh, pick_dm})
                | {rnh_uf, cnh_uf, dm_uf};
        end
    end

    // word selection for the chosen record
    assign sel_w0 = pick_ins ? ins_w0_reg
        : pick_dm ? dm_w0
        : pick_cnh ? cnh_w0
        : rnh_w0;
    assign sel_w1 = pick_ins ? ins_w1_reg : pick_dm ? dm_ip_reg : clk_ip_reg;
    assign sel_w2 = pick_ins ? ins_w2_reg : pick_dm ? dm_w2
        : 64'h0000_0000_0000_0000;

    // a word leaves when the ring accepts it
    assign word_taken = rec_valid && rec_ready;
    // next word to show once the current one is accepted
    assign next_word = words_reg[word_idx_reg + 2'h1];

    // emitter walks four words out with valid/ready
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            state_reg <= PERG_ST_IDLE;
            word_idx_reg <= 2'h0;
            for (int i = 0; i < PERG_WORDS; i++) begin
                words_reg[i] <= 64'h0000_0000_0000_0000;
            end
        end else begin
            unique case (state_reg)
                // load all four words at the start of a record
                PERG_ST_IDLE: begin
                    if (start_emit) begin
                        words_reg[0] <= sel_w0;
                        words_reg[1] <= sel_w1;
                        words_reg[2] <= sel_w2;
                        words_reg[3] <= stamp_word;
                        word_idx_reg <= 2'h0;
                        state_reg <= PERG_ST_EMIT;
                    end
                end
                // step through the words, back to idle after the last
                PERG_ST_EMIT: begin
                    if (word_taken) begin
                        word_idx_reg <= word_idx_reg + 2'h1;
                        if (rec_last) begin
                            state_reg <= PERG_ST_IDLE;
                        end
                    end
                end
            endcase
        end
    end

    // busy from one cycle after the start decision until one cycle after the emitter is idle again
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            busy <= 1'b0;
        end else begin
            busy <= (state_reg == PERG_ST_EMIT) || start_emit;
        end
    end

    // registered output stage
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            rec_valid <= 1'b0;
            rec_offset <= PERG_OFS_W0;
            rec_data <= 64'h0000_0000_0000_0000;
            rec_last <= 1'b0;
        end else begin
            // first word goes out with the start decision
            if (start_emit) begin
                rec_valid <= 1'b1;
                rec_offset <= PERG_OFS_W0;
                rec_data <= sel_w0;
                rec_last <= 1'b0;
            end else if (word_taken) begin
                if (rec_last) begin
                    rec_valid <= 1'b0;
                    rec_last <= 1'b0;
                end else begin
                    rec_offset <= rec_offset + PERG_OFS_STEP;
                    rec_data <= next_word;
                    rec_last <= (word_idx_reg == 2'h2);
                end
            end
        end
    end
endmodule // pergen_top

// ---- design/pergen_pkg.sv ----
// constants shared by the profiling event record generator
package pergen_pkg;
    localparam logic [7:0] PERG_CODE_DMISS = 8'h04;
    localparam logic [7:0] PERG_CODE_CNH = 8'h05;
    localparam logic [7:0] PERG_CODE_RNH = 8'h06;
    localparam logic [7:0] PERG_CODE_INS = 8'hFF;
    localparam int PERG_DAV_BIT = 28;
    localparam int PERG_SRC_LSB = 29;
    localparam int PERG_CORE_LSB = 8;
    localparam int PERG_IMM_LSB = 16;
    localparam int PERG_HI_LSB = 32;
    localparam int PERG_WORDS = 4;
    localparam logic [4:0] PERG_OFS_W0 = 5'h00;
    localparam logic [4:0] PERG_OFS_STEP = 5'h08;
    localparam logic [31:0] PERG_CNT_RESET = 32'h0000_0000;
    localparam logic [15:0] PERG_RATIO_RESET = 16'h0000;
    typedef enum logic [1:0] {PERG_K_DMISS, PERG_K_CNH, PERG_K_RNH, PERG_K_INS} perg_kind_t;
    typedef enum {PERG_ST_IDLE, PERG_ST_EMIT} perg_state_t;
endpackage

// ---- design/perg_counter.sv ----
// signed event counter that flags the step into negative
`timescale 1ns/1ns
module perg_counter #(
    parameter int WIDTH = 32,
    parameter int FRAC = 16
) (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic load,
    input wire logic [WIDTH-1:0] load_value,
    input wire logic dec,
    input wire logic [WIDTH+FRAC-1:0] dec_amount,
    output logic underflow
);
    logic [WIDTH+FRAC-1:0] count_reg;
    logic [WIDTH+FRAC-1:0] count_next;
    logic went_negative;
    // subtract the step; fractional bits let the step be less than one count
    assign count_next = count_reg - dec_amount;
    assign went_negative = dec && !count_reg[WIDTH+FRAC-1] && count_next[WIDTH+FRAC-1];
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            count_reg <= '0;
            underflow <= 1'b0;
        end else begin
            underflow <= went_negative;
            if (load) begin
                count_reg <= {load_value, {FRAC{1'b0}}};
            end else if (dec) begin
                count_reg <= count_next;
            end
        end
    end
endmodule // perg_counter

// ---- tb/pergen_assertions.sv ----
// port-level checks on the record generator output stream
`timescale 1ns/1ns
module pergen_assertions
    import pergen_pkg::*;
(
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic [7:0] core_id,
    input wire logic record_time_value_capture_flag,
    input wire logic user_record_insert_instr,
    input wire logic rec_ready,
    input wire logic rec_valid,
    input wire logic [4:0] rec_offset,
    input wire logic [63:0] rec_data,
    input wire logic rec_last,
    input wire logic busy
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!reset_n);
    logic [7:0] kind_reg;
    logic dav_reg;
    // kind and address flag of the record in flight
    always_ff @(posedge sys_clk) begin
        if (rec_valid && rec_offset == 5'h00) begin
            kind_reg <= rec_data[7:0];
            dav_reg <= rec_data[PERG_DAV_BIT];
        end
    end
    sequence s_take;
        rec_valid && rec_ready;
    endsequence
    sequence s_head;
        rec_valid && rec_offset == 5'h00;
    endsequence
    property p_hold;
        rec_valid && !rec_ready |=> rec_valid && $stable(rec_data) && $stable(rec_offset);
    endproperty
    property p_first;
        $rose(rec_valid) |-> rec_offset == 5'h00;
    endproperty
    property p_step;
        s_take ##0 !rec_last |=> rec_valid && rec_offset == $past(rec_offset) + 5'h08;
    endproperty
    property p_last;
        rec_valid |-> rec_last == (rec_offset == 5'h18);
    endproperty
    property p_gap;
        s_take ##0 rec_last |=> !rec_valid;
    endproperty
    property p_core;
        s_head |-> rec_data[15:8] == core_id;
    endproperty
    property p_miss_resv;
        s_head ##0 rec_data[7:0] == 8'h04 |-> rec_data[27:16] == 12'h000;
    endproperty
    property p_gen_resv;
        s_head ##0 (rec_data[7:0] inside {8'h05, 8'h06}) |-> rec_data[63:16] == 48'h0;
    endproperty
    property p_w2_zero;
        rec_valid && rec_offset == 5'h10 && (kind_reg inside {8'h05, 8'h06}
            || (kind_reg == 8'h04 && !dav_reg)) |-> rec_data == 64'h0;
    endproperty
    property p_ts;
        rec_valid && rec_offset == 5'h18 && !record_time_value_capture_flag |-> rec_data == 64'h0;
    endproperty
    property p_busy;
        rec_valid |-> busy;
    endproperty
    property p_ins;
        user_record_insert_instr && !busy |-> ##[1:4] s_head ##0 rec_data[7:0] == 8'hFF;
    endproperty
    a_hold: assert property (p_hold) else $error("record word changed while stalled");
    a_first: assert property (p_first) else $error("record not started at offset 0");
    a_step: assert property (p_step) else $error("offset did not step by 8");
    a_last: assert property (p_last) else $error("last flag off word 24");
    a_gap: assert property (p_gap) else $error("no idle cycle after record");
    a_core: assert property (p_core) else $error("core id byte wrong");
    a_miss_resv: assert property (p_miss_resv) else $error("miss reserved bits set");
    a_gen_resv: assert property (p_gen_resv) else $error("word 0 dirty");
    a_w2_zero: assert property (p_w2_zero) else $error("w2 dirty");
    a_busy: assert property (p_busy) else $error("record out while not busy");
    a_ts: assert property (p_ts) else $error("stamp present without flag");
    a_ins: assert property (p_ins) else $error("insert record missing");
endmodule // pergen_assertions

bind pergen_top pergen_assertions pergen_assertions_i (.sys_clk(sys_clk), .reset_n(reset_n),
    .core_id(core_id), .record_time_value_capture_flag(record_time_value_capture_flag),
    .user_record_insert_instr(user_record_insert_instr), .rec_ready(rec_ready),
    .rec_valid(rec_valid), .rec_offset(rec_offset), .rec_data(rec_data),
    .rec_last(rec_last), .busy(busy));

// ---- tb/perg_ring_sink.sv ----
// memory ring buffer taking record words, with stalls
`timescale 1ns/1ns
module perg_ring_sink (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic stall,
    input wire logic rec_valid,
    input wire logic [4:0] rec_offset,
    input wire logic [63:0] rec_data,
    input wire logic rec_last,
    output logic rec_ready
);
    logic [63:0] ring [0:63];
    int n_rec;
    assign rec_ready = !stall;
    // store each accepted word at its byte offset, count whole records
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            n_rec <= 0;
        end else if (rec_valid && rec_ready) begin
            ring[(n_rec % 16) * 4 + rec_offset / 8] <= rec_data;
            if (rec_last) begin
                n_rec <= n_rec + 1;
            end
        end
    end
endmodule // perg_ring_sink

// ---- tb/pergen_top_test.sv ----
// self-checking bench for the record generator
`timescale 1ns/1ns
module pergen_top_test;
    import pergen_pkg::*;
    logic sys_clk = 1'h0, reset_n = 1'h0, counters_load = 1'h0, halt_instr = 1'h1;
    logic stop_clock_input = 1'h0, dmiss_event = 1'h0, user_record_insert_instr = 1'h0;
    logic record_time_value_capture_flag = 1'h0, data_addr_valid = 1'h0, legacy_mode = 1'h0;
    logic stall = 1'h0, rec_ready, rec_valid, rec_last, busy;
    logic [7:0] core_id = 8'h00;
    logic [2:0] miss_source_code = 3'h0;
    logic [4:0] rec_offset;
    logic [15:0] ref_ratio = 16'h0000, insert_imm = 16'h0000;
    logic [31:0] dmiss_interval = 32'h0, cnh_interval = 32'h3, rnh_interval = 32'h1;
    logic [31:0] miss_latency = 32'h0, insert_operand_word = 32'h0;
    logic [63:0] perf_record_time_value = 64'h0, instr_location = 64'h0, rec_data;
    logic [63:0] missed_data_location = 64'h0, insert_operand_quad = 64'h0;
    logic [63:0] exp_q[$];
    int n_mismatch = 0, n_tests = 0, n_seen = 0, n_word = 0;
    pergen_top pergen_top_i (.sys_clk, .reset_n, .core_id, .record_time_value_capture_flag,
        .perf_record_time_value, .instr_location, .dmiss_interval, .cnh_interval, .rnh_interval,
        .counters_load, .ref_ratio, .stop_clock_input, .halt_instr, .dmiss_event,
        .missed_data_location, .data_addr_valid, .miss_source_code, .miss_latency,
        .user_record_insert_instr, .insert_imm, .insert_operand_word, .insert_operand_quad,
        .legacy_mode, .rec_ready, .rec_valid, .rec_offset, .rec_data, .rec_last, .busy);
    perg_ring_sink perg_ring_sink_i (.sys_clk, .reset_n, .stall, .rec_valid, .rec_offset,
        .rec_data, .rec_last, .rec_ready);
    // clock and random sink stalls
    always #50 sys_clk = ~sys_clk;
    always @(posedge sys_clk) stall <= ($urandom % 4 == 0);
    task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic close_out();
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic mix(input logic ts);
        core_id <= 8'($urandom);
        record_time_value_capture_flag <= ts;
        perf_record_time_value <= {$urandom, $urandom};
        instr_location <= {$urandom, $urandom};
    endtask
    task automatic expect_rec(input logic [63:0] w0, input logic [63:0] w2);
        exp_q.push_back(w0);
        exp_q.push_back(instr_location);
        exp_q.push_back(w2);
        exp_q.push_back(record_time_value_capture_flag ? perf_record_time_value : 64'h0);
    endtask
    task automatic load(input logic [31:0] c, input logic [15:0] q);
        @(posedge sys_clk);
        cnh_interval <= c;
        ref_ratio <= q;
        counters_load <= 1'h1;
        @(posedge sys_clk);
        counters_load <= 1'h0;
    endtask
    task automatic take(input int n);
        int k;
        k = 0;
        while (perg_ring_sink_i.n_rec < n_seen + n && k < 300) begin
            @(posedge sys_clk);
            k++;
        end
        repeat (16) @(posedge sys_clk);
        n_seen += n;
        check("records", 64'(perg_ring_sink_i.n_rec), 64'(n_seen));
        check("busy", 64'(busy), 64'h0);
        while (exp_q.size() > 0) begin
            check("word", perg_ring_sink_i.ring[n_word % 64], exp_q.pop_front());
            n_word++;
        end
    endtask
    // main sequence: inserts, misses, core clocks, reference clocks
    initial begin
        void'($urandom(76613));
        repeat (2) @(posedge sys_clk);
        reset_n <= 1'h1;
        for (int i = 0; i < 4; i++) begin
            @(posedge sys_clk);
            mix(i[1]);
            legacy_mode <= i[0];
            insert_imm <= 16'($urandom);
            insert_operand_word <= $urandom;
            insert_operand_quad <= {$urandom, $urandom};
            user_record_insert_instr <= 1'h1;
            @(posedge sys_clk);
            user_record_insert_instr <= 1'h0;
            expect_rec({insert_operand_word, insert_imm, core_id, 8'hFF}, legacy_mode ?
                {32'h0, insert_operand_quad[31:0]} : insert_operand_quad);
            take(1);
        end
        for (int i = 0; i < 8; i++) begin
            mix(i[2]);
            dmiss_interval <= 32'(i % 2);
            load(32'h3, 16'h0000);
            miss_source_code <= 3'(i);
            data_addr_valid <= i[0];
            // interval plus one misses; only the last goes negative
            for (int m = 0; m <= i % 2; m++) begin
                missed_data_location <= {$urandom, $urandom};
                miss_latency <= $urandom;
                dmiss_event <= 1'h1;
                @(posedge sys_clk);
            end
            dmiss_event <= 1'h0;
            expect_rec({miss_latency, miss_source_code, data_addr_valid, 12'h0, core_id, 8'h04},
                data_addr_valid ? missed_data_location : 64'h0);
            take(1);
        end
        // core clocks: three unhalted cycles stay at zero, the fourth goes negative
        mix(1'h1);
        load(32'h3, 16'h0000);
        halt_instr <= 1'h0;
        repeat (3) @(posedge sys_clk);
        halt_instr <= 1'h1;
        take(0);
        halt_instr <= 1'h0;
        @(posedge sys_clk);
        halt_instr <= 1'h1;
        expect_rec({48'h0, core_id, 8'h05}, 64'h0);
        take(1);
        // reference clocks at half rate, gated by the stop pin
        mix(1'h0);
        load(32'h7FFF_FFFF, 16'h8000);
        stop_clock_input <= 1'h1;
        repeat (4) @(posedge sys_clk);
        halt_instr <= 1'h0;
        stop_clock_input <= 1'h0;
        repeat (2) @(posedge sys_clk);
        stop_clock_input <= 1'h1;
        take(0);
        stop_clock_input <= 1'h0;
        @(posedge sys_clk);
        stop_clock_input <= 1'h1;
        repeat (4) @(posedge sys_clk);
        halt_instr <= 1'h1;
        expect_rec({48'h0, core_id, 8'h06}, 64'h0);
        take(1);
        close_out();
    end
    // watchdog against a hung run
    initial begin
        #(3000 * 100);
        n_mismatch++;
        close_out();
    end
endmodule // pergen_top_test
